// ===== pkg/supply_supervisor_defines.svh
// supervisor constants
// assumes a 50 MHz clock
`ifndef SUPPLY_SUPERVISOR_DEFINES_SVH
`define SUPPLY_SUPERVISOR_DEFINES_SVH

`define CLK_HZ 50000000
`define MS_PER_S 1000
`define SAVE_BUS_DELAY_MS 2
`define OSC_START_DELAY_MS 2
`define BUS_FILTER_MS 2
`define WD_PULSE_MS 1
`define CNT_W 25

// watchdog timeout and minimum period in ms, entry 15 first
`define WD_TIMEOUT_MS_TABLE {10'h20c, 10'h1ec, 10'h1cb, 10'h1aa, 10'h189, 10'h168, \
    10'h148, 10'h127, 10'h106, 10'h0e5, 10'h0c5, 10'h0a4, 10'h083, 10'h062, 10'h042, 10'h021}
`define WD_MIN_MS_TABLE {10'h01f, 10'h01e, 10'h01d, 10'h01b, 10'h019, 10'h017, \
    10'h014, 10'h012, 10'h010, 10'h00e, 10'h00c, 10'h00a, 10'h008, 10'h006, 10'h004, 10'h002}
`define WD_MS_W 10

`define ADDR_STATUS 4'h0
`define ADDR_WDOG 4'h4

`define ST_STATE_LSB 0
`define ST_TW 2
`define ST_SHUTDOWN 3
`define ST_BUS 4
`define ST_FILT 5
`define ST_ADJ 6
`define ST_V20 7
`define ST_OSC 8
`define WD_EN_BIT 0
`define WD_SEL_LSB 4

`define CODE_RESET 2'h0
`define CODE_STARTUP 2'h1
`define CODE_STANDBY 2'h2
`define CODE_NORMAL 2'h3

`define CLK_OFF 2'h0
`define CLK_INT4 2'h1
`define CLK_XTAL8 2'h2
`define CLK_XTAL16 2'h3

// synchroniser lanes
`define NSYNC 17
`define SY_F14 0
`define SY_F12 1
`define SY_F10 2
`define SY_F6V5 3
`define SY_FHI 4
`define SY_FLO 5
`define SY_B20 6
`define SY_BHI 7
`define SY_BLO 8
`define SY_FIXOK 9
`define SY_ADJOK 10
`define SY_V20OK 11
`define SY_TW 12
`define SY_TSD 13
`define SY_OSC 14
`define SY_RATE 15
`define SY_TRIM 16

`endif

// ===== pkg/supply_supervisor_pkg.sv
// supervisor types
// assumes nothing else
`default_nettype none
package supply_supervisor_pkg;
    typedef enum logic [1:0] {
        SUP_RESET,
        SUP_STARTUP,
        SUP_STANDBY,
        SUP_NORMAL
    } sup_state_t;
endpackage
`default_nettype wire

// ===== hw/supply_supervisor_watchdog.sv
// supervisor sequencer, watchdog, register slave
// assumes asynchronous comparator inputs
// Notes on behaviour
// [RQ1] save low under 14 V
// [RQ2] save low after 2 ms bus low
// [RQ3] host reset low under 12 V
// [RQ4] outputs pull low only
// [RQ5] thermal warning: save low, bit
// [RQ6] shutdown: reset, sticky flag, off
// [RQ7] shutdown gone: start-up, stand-by
// [RQ8] warning bit follows condition
// [RQ9] shutdown flag clears on read
// [RQ10] watchdog idle until enabled
// [RQ11] host refreshes before timeout
// [RQ12] bad refresh pulses host reset
// [RQ13] selector picks timeout pair
// [RQ14] reset: fixed buck on, 10 V
// [RQ15] rail up, trim read, stand-by
// [RQ16] oscillator 2 ms into stand-by
// [RQ17] rails need filtered high
// [RQ18] normal only when all good
// [RQ19] bus low: stand-by, save low
// [RQ20] low supply: rails off, reset
// [RQ21] host clock 4 MHz or selected
// [RQ22] rails kept unless rail fault
// [RQ23] reset state clears watchdog
`default_nettype none
`include "supply_supervisor_defines.svh"

module sync3 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [W-1:0] q_next;
    always_comb
    begin
        q_next = q_reg;
        // a lane changes only once stages two and three agree
        for (int i = 0; i < W; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                q_next[i] = s3_reg[i];
            end
        end
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end
    assign q = q_reg;
endmodule

module supply_supervisor_watchdog #(
    parameter int CYCLES_PER_MS = `CLK_HZ / `MS_PER_S,
    parameter int SAVE_DELAY_CYC = `SAVE_BUS_DELAY_MS * CYCLES_PER_MS,
    parameter int OSC_DELAY_CYC = `OSC_START_DELAY_MS * CYCLES_PER_MS,
    parameter int BUS_FILTER_CYC = `BUS_FILTER_MS * CYCLES_PER_MS,
    parameter int WD_PULSE_CYC = `WD_PULSE_MS * CYCLES_PER_MS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic filteredAbove14v,
    input wire logic filteredAbove12v,
    input wire logic filteredAbove10v,
    input wire logic filteredAbove6v5,
    input wire logic filterHighThreshold,
    input wire logic filterLowThreshold,
    input wire logic busAbove20v,
    input wire logic busHighThreshold,
    input wire logic busLowThreshold,
    input wire logic fixedRailOk,
    input wire logic adjustableRailOk,
    input wire logic linear20vRailOk,
    input wire logic thermalWarning,
    input wire logic thermalShutdown,
    input wire logic oscRunning,
    input wire logic hostClockRateSel,
    input wire logic trimDone,
    output logic hostResetNOut,
    output logic hostResetNOe_n,
    output logic saveWarnNOut,
    output logic saveWarnNOe_n,
    output logic fixedBuckEn,
    output logic adjustableBuckEn,
    output logic linear20vEn,
    output logic oscEnable,
    output logic trimReadReq,
    output logic [1:0] hostClockMode,
    output logic hostSerialActive,
    output supply_supervisor_pkg::sup_state_t supState
);
    import supply_supervisor_pkg::*;

    logic [`NSYNC-1:0] sy;
    sync3 #(.W(`NSYNC)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({trimDone, hostClockRateSel, oscRunning, thermalShutdown, thermalWarning,
            linear20vRailOk,
            adjustableRailOk, fixedRailOk, busLowThreshold, busHighThreshold, busAbove20v,
            filterLowThreshold, filterHighThreshold, filteredAbove6v5, filteredAbove10v,
            filteredAbove12v, filteredAbove14v}),
        .q(sy)
    );

    wire logic trimSync = sy[`SY_TRIM];
    wire logic thermal_shutdown = sy[`SY_TSD];
    wire logic tw = sy[`SY_TW];

    // one wait cycle per access
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    wire logic busReq = read | write;
    wire logic done = busReq & ~wait_reg;
    wire logic wrWdog = done & write & (address == `ADDR_WDOG) & byteenable[0];
    wire logic rdStatus = done & read & (address == `ADDR_STATUS);

    // sequencer state and status bits
    sup_state_t state_reg, state_next;
    logic fromNormal_reg, fromNormal_next;
    logic causeOsc_reg, causeOsc_next;
    logic causeRail_reg, causeRail_next;
    logic busBit_reg, busBit_next;
    logic filtBit_reg, filtBit_next;
    logic shutFlag_reg, shutFlag_next;
    logic fixedOn_reg, fixedOn_next;
    logic oscOn_reg, oscOn_next;
    logic [`CNT_W-1:0] stbyCnt_reg, stbyCnt_next;
    logic [`CNT_W-1:0] busLowCnt_reg, busLowCnt_next;
    logic [`CNT_W-1:0] b20Cnt_reg, b20Cnt_next;
    logic busLate_reg, busLate_next;

    // watchdog
    logic wdog_enable_reg, wdog_enable_next;
    logic [3:0] wdSel_reg, wdSel_next;
    logic [`CNT_W-1:0] wdCnt_reg, wdCnt_next;
    logic [`CNT_W-1:0] wdPulse_reg, wdPulse_next;

    // outputs
    logic hostRstDrv_reg, hostRstDrv_next;
    logic saveDrv_reg, saveDrv_next;
    logic adjOn_reg, adjOn_next;
    logic trimReq_reg, trimReq_next;
    logic [1:0] clkMode_reg, clkMode_next;
    logic serial_reg, serial_next;

    logic [1:0] stateCode;
    logic [`WD_MS_W-1:0] toMs, minMs;
    logic [`CNT_W-1:0] toCyc, minCyc;
    logic normalOk;

    localparam logic [16*`WD_MS_W-1:0] TO_TABLE = `WD_TIMEOUT_MS_TABLE;
    localparam logic [16*`WD_MS_W-1:0] MIN_TABLE = `WD_MIN_MS_TABLE;
    localparam logic [`CNT_W-1:0] SAVE_DLY = `CNT_W'(SAVE_DELAY_CYC);
    localparam logic [`CNT_W-1:0] OSC_DLY = `CNT_W'(OSC_DELAY_CYC);
    localparam logic [`CNT_W-1:0] BUS_FLT = `CNT_W'(BUS_FILTER_CYC);
    localparam logic [`CNT_W-1:0] WD_PULSE = `CNT_W'(WD_PULSE_CYC);
    localparam logic [`CNT_W-1:0] CYC_MS = `CNT_W'(CYCLES_PER_MS);

    always_comb
    begin
        toMs = TO_TABLE[wdSel_reg*`WD_MS_W +: `WD_MS_W]; // RQ13
        minMs = MIN_TABLE[wdSel_reg*`WD_MS_W +: `WD_MS_W]; // RQ13
        toCyc = `CNT_W'(toMs * CYC_MS);
        minCyc = `CNT_W'(minMs * CYC_MS);
        case (state_reg)
            SUP_RESET: stateCode = `CODE_RESET;
            SUP_STARTUP: stateCode = `CODE_STARTUP;
            SUP_STANDBY: stateCode = `CODE_STANDBY;
            SUP_NORMAL: stateCode = `CODE_NORMAL;
            default: stateCode = `CODE_RESET;
        endcase
        normalOk = sy[`SY_OSC] & ~tw & ~thermal_shutdown & busBit_reg & filtBit_reg
            & sy[`SY_ADJOK] & sy[`SY_V20OK]; // RQ18
    end

    // register slave
    always_comb
    begin
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        if (busReq & wait_reg)
        begin
            wait_next = 1'b0;
            rdata_next = 32'h0;
            if (address == `ADDR_STATUS)
            begin
                rdata_next[`ST_STATE_LSB +: 2] = stateCode;
                rdata_next[`ST_TW] = tw; // RQ8
                rdata_next[`ST_SHUTDOWN] = shutFlag_reg;
                rdata_next[`ST_BUS] = busBit_reg;
                rdata_next[`ST_FILT] = filtBit_reg;
                rdata_next[`ST_ADJ] = sy[`SY_ADJOK];
                rdata_next[`ST_V20] = sy[`SY_V20OK];
                rdata_next[`ST_OSC] = sy[`SY_OSC];
            end
            else if (address == `ADDR_WDOG)
            begin
                rdata_next[`WD_EN_BIT] = wdog_enable_reg;
                rdata_next[`WD_SEL_LSB +: 4] = wdSel_reg;
            end
        end
    end

    // sequencer
    always_comb
    begin
        state_next = state_reg;
        fromNormal_next = fromNormal_reg;
        causeOsc_next = causeOsc_reg;
        causeRail_next = causeRail_reg;
        busBit_next = busBit_reg;
        filtBit_next = filtBit_reg;
        fixedOn_next = fixedOn_reg;
        oscOn_next = oscOn_reg;
        stbyCnt_next = stbyCnt_reg;
        trimReq_next = 1'b0;
        // set wins over the clearing read
        shutFlag_next = shutFlag_reg;
        if (rdStatus & ~thermal_shutdown)
        begin
            shutFlag_next = 1'b0; // RQ9
        end
        if (thermal_shutdown)
        begin
            shutFlag_next = 1'b1; // RQ6
        end
        if (sy[`SY_FHI])
        begin
            filtBit_next = 1'b1;
        end
        else if (!sy[`SY_FLO])
        begin
            filtBit_next = 1'b0;
        end
        // bus low filter
        busLowCnt_next = '0;
        if (!sy[`SY_BLO])
        begin
            busLowCnt_next = (busLowCnt_reg == BUS_FLT) ? busLowCnt_reg : busLowCnt_reg + 1'b1;
        end
        if (busLowCnt_reg == BUS_FLT)
        begin
            busBit_next = 1'b0; // RQ19
        end
        else if (sy[`SY_BHI] & (state_reg != SUP_RESET) & (state_reg != SUP_STARTUP))
        begin
            busBit_next = 1'b1;
        end
        if (stbyCnt_reg != OSC_DLY)
        begin
            stbyCnt_next = stbyCnt_reg + 1'b1;
        end
        case (state_reg)
            SUP_RESET:
            begin
                oscOn_next = 1'b0;
                busBit_next = 1'b0;
                fixedOn_next = 1'b0;
                if (!thermal_shutdown & sy[`SY_F10])
                begin
                    fixedOn_next = 1'b1; // RQ14
                    state_next = SUP_STARTUP; // RQ7
                end
            end
            SUP_STARTUP:
            begin
                busBit_next = 1'b0;
                if (sy[`SY_FIXOK] & !trimSync)
                begin
                    trimReq_next = 1'b1; // RQ15
                end
                if (sy[`SY_FIXOK] & trimSync)
                begin
                    state_next = SUP_STANDBY; // RQ15
                    busBit_next = sy[`SY_BHI]; // RQ15
                    fromNormal_next = 1'b0;
                    causeOsc_next = 1'b0;
                    causeRail_next = 1'b0;
                    stbyCnt_next = '0;
                end
            end
            SUP_STANDBY:
            begin
                if (stbyCnt_reg == OSC_DLY)
                begin
                    oscOn_next = 1'b1; // RQ16
                    // rail fault hold lasts one delay, then a retry
                    causeRail_next = 1'b0;
                end
                if (normalOk)
                begin
                    state_next = SUP_NORMAL; // RQ18
                end
            end
            SUP_NORMAL:
            begin
                if (!normalOk)
                begin
                    state_next = SUP_STANDBY; // RQ19
                    fromNormal_next = 1'b1;
                    causeOsc_next = ~sy[`SY_OSC];
                    causeRail_next = ~sy[`SY_ADJOK] | ~sy[`SY_V20OK];
                    stbyCnt_next = '0;
                end
            end
            default: state_next = SUP_RESET;
        endcase
        if (!sy[`SY_F6V5])
        begin
            fixedOn_next = 1'b0; // RQ20
        end
        if ((!fixedOn_reg & !sy[`SY_FIXOK] & (state_reg != SUP_RESET)) | thermal_shutdown)
        begin
            state_next = SUP_RESET; // RQ6 RQ20
            fixedOn_next = 1'b0; // RQ6
            oscOn_next = 1'b0;
        end
    end

    // watchdog window measured from the last enable write, refresh or timeout
    always_comb
    begin
        wdog_enable_next = wdog_enable_reg;
        wdSel_next = wdSel_reg;
        wdCnt_next = wdCnt_reg;
        wdPulse_next = (wdPulse_reg != '0) ? wdPulse_reg - 1'b1 : wdPulse_reg;
        if (wdog_enable_reg)
        begin
            wdCnt_next = wdCnt_reg + 1'b1;
            if (wdCnt_reg >= toCyc)
            begin
                wdPulse_next = WD_PULSE; // RQ12
                wdCnt_next = '0;
            end
        end
        if (wrWdog)
        begin
            wdSel_next = writedata[`WD_SEL_LSB +: 4];
            wdog_enable_next = writedata[`WD_EN_BIT];
            wdCnt_next = '0; // RQ10
            if (wdog_enable_reg & writedata[`WD_EN_BIT] & (wdCnt_reg < minCyc))
            begin
                wdPulse_next = WD_PULSE; // RQ12
            end
        end
        if (state_reg == SUP_RESET)
        begin
            wdog_enable_next = 1'b0; // RQ23
            wdCnt_next = '0; // RQ23
        end
    end

    // output drive
    always_comb
    begin
        b20Cnt_next = '0;
        if (!sy[`SY_B20])
        begin
            b20Cnt_next = (b20Cnt_reg == SAVE_DLY) ? b20Cnt_reg : b20Cnt_reg + 1'b1;
        end
        busLate_next = (b20Cnt_reg == SAVE_DLY);
        hostRstDrv_next = (state_next == SUP_RESET) | (state_next == SUP_STARTUP)
            | ~sy[`SY_F12] // RQ3
            | (wdPulse_next != '0); // RQ12
        saveDrv_next = ~sy[`SY_F14] // RQ1
            | busLate_next // RQ2
            | tw // RQ5
            | (state_next != SUP_NORMAL); // RQ18 RQ19
        adjOn_next = filtBit_next & ((state_next == SUP_NORMAL)
            | ((state_next == SUP_STANDBY) & ~(fromNormal_next & causeRail_next))); // RQ17 RQ22
        if (!sy[`SY_FLO])
        begin
            adjOn_next = 1'b0; // RQ20
        end
        clkMode_next = `CLK_OFF;
        if ((state_next == SUP_NORMAL)
            | ((state_next == SUP_STANDBY) & fromNormal_next & ~causeOsc_next))
        begin
            clkMode_next = sy[`SY_RATE] ? `CLK_XTAL16 : `CLK_XTAL8; // RQ21
        end
        else if (state_next == SUP_STANDBY)
        begin
            clkMode_next = `CLK_INT4; // RQ21
        end
        serial_next = (state_next == SUP_STANDBY) | (state_next == SUP_NORMAL); // RQ22
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
            state_reg <= SUP_RESET;
            fromNormal_reg <= 1'b0;
            causeOsc_reg <= 1'b0;
            causeRail_reg <= 1'b0;
            busBit_reg <= 1'b0;
            filtBit_reg <= 1'b0;
            shutFlag_reg <= 1'b0;
            fixedOn_reg <= 1'b0;
            oscOn_reg <= 1'b0;
            stbyCnt_reg <= '0;
            busLowCnt_reg <= '0;
            b20Cnt_reg <= '0;
            busLate_reg <= 1'b0;
            wdog_enable_reg <= 1'b0;
            wdSel_reg <= 4'h0;
            wdCnt_reg <= '0;
            wdPulse_reg <= '0;
            hostRstDrv_reg <= 1'b1;
            saveDrv_reg <= 1'b1;
            adjOn_reg <= 1'b0;
            trimReq_reg <= 1'b0;
            clkMode_reg <= `CLK_OFF;
            serial_reg <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            fromNormal_reg <= fromNormal_next;
            causeOsc_reg <= causeOsc_next;
            causeRail_reg <= causeRail_next;
            busBit_reg <= busBit_next;
            filtBit_reg <= filtBit_next;
            shutFlag_reg <= shutFlag_next;
            fixedOn_reg <= fixedOn_next;
            oscOn_reg <= oscOn_next;
            stbyCnt_reg <= stbyCnt_next;
            busLowCnt_reg <= busLowCnt_next;
            b20Cnt_reg <= b20Cnt_next;
            busLate_reg <= busLate_next;
            wdog_enable_reg <= wdog_enable_next;
            wdSel_reg <= wdSel_next;
            wdCnt_reg <= wdCnt_next;
            wdPulse_reg <= wdPulse_next;
            hostRstDrv_reg <= hostRstDrv_next;
            saveDrv_reg <= saveDrv_next;
            adjOn_reg <= adjOn_next;
            trimReq_reg <= trimReq_next;
            clkMode_reg <= clkMode_next;
            serial_reg <= serial_next;
        end
    end

    // open drain: data always low, only the enable moves
    logic odLow_reg;
    always_ff @(posedge clock)
    begin
        odLow_reg <= 1'b0; // RQ4
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign hostResetNOut = odLow_reg;
    assign hostResetNOe_n = ~hostRstDrv_reg; // RQ4
    assign saveWarnNOut = odLow_reg;
    assign saveWarnNOe_n = ~saveDrv_reg; // RQ4
    assign fixedBuckEn = fixedOn_reg;
    assign adjustableBuckEn = adjOn_reg;
    assign linear20vEn = adjOn_reg;
    assign oscEnable = oscOn_reg;
    assign trimReadReq = trimReq_reg;
    assign hostClockMode = clkMode_reg;
    assign hostSerialActive = serial_reg;
    assign supState = state_reg;
endmodule
`default_nettype wire

// ===== verif/supply_supervisor_chk.sv
// supervisor output checks
// assumes binding into the design
`default_nettype none
module supply_supervisor_chk #(
    parameter int CYCLES_PER_MS = 10
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic filteredAbove14v,
    input wire logic filteredAbove12v,
    input wire logic filterLowThreshold,
    input wire logic busAbove20v,
    input wire logic thermalWarning,
    input wire logic thermalShutdown,
    input wire logic hostResetNOut,
    input wire logic hostResetNOe_n,
    input wire logic saveWarnNOut,
    input wire logic saveWarnNOe_n,
    input wire logic adjustableBuckEn,
    input wire logic linear20vEn,
    input wire logic oscEnable,
    input wire logic [1:0] hostClockMode,
    input wire logic hostSerialActive,
    input wire logic trimReadReq,
    input wire supply_supervisor_pkg::sup_state_t supState
);
    timeunit 1ns;
    timeprecision 1ns;
    import supply_supervisor_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic [15:0] lowCnt_reg;
    logic [15:0] lowCnt_next;
    // saturates, so a long brown-out cannot wrap to zero
    always_comb
        lowCnt_next = busAbove20v ? 16'h0 : lowCnt_reg + {15'h0, ~&lowCnt_reg};
    always_ff @(posedge clock)
        lowCnt_reg <= rst_n ? lowCnt_next : 16'h0;
    od_low_a: assert property (!hostResetNOut && !saveWarnNOut)
        else $error("od data high");
    save_14v_a: assert property (!filteredAbove14v[*7] |-> !saveWarnNOe_n)
        else $error("save under 14 V");
    reset_12v_a: assert property (!filteredAbove12v[*7] |-> !hostResetNOe_n)
        else $error("reset under 12 V");
    // sync plus counter slack
    save_bus_a: assert property (lowCnt_reg > 2 * CYCLES_PER_MS + 8 |-> !saveWarnNOe_n)
        else $error("save on bus low");
    save_warn_a: assert property (thermalWarning[*7] |-> !saveWarnNOe_n)
        else $error("save on warning");
    tsd_reset_a: assert property (thermalShutdown[*8] |->
        supState == SUP_RESET && !adjustableBuckEn && !oscEnable)
        else $error("shutdown reset");
    save_norm_a: assert property (
        supState != SUP_NORMAL && $past(supState) != SUP_NORMAL |-> !saveWarnNOe_n)
        else $error("save outside normal");
    rails_low_a: assert property (
        !filterLowThreshold[*8] |-> !adjustableBuckEn && !linear20vEn)
        else $error("rails on when low");
    early_off_a: assert property (supState inside {SUP_RESET, SUP_STARTUP} &&
        $past(supState) inside {SUP_RESET, SUP_STARTUP} |-> !hostSerialActive &&
        hostClockMode == 2'h0)
        else $error("serial too early");
    trim_req_a: assert property (trimReadReq |-> $past(supState) == SUP_STARTUP)
        else $error("trim outside start-up");
    normal_c: cover property (supState == SUP_NORMAL);
    wdog_c: cover property (supState == SUP_NORMAL && $fell(hostResetNOe_n));
    tsd_c: cover property (thermalShutdown && supState == SUP_RESET);
endmodule
bind supply_supervisor_watchdog supply_supervisor_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (.*);
`default_nettype wire

// ===== verif/host_model.sv
// host side of reset and warning lines
// assumes split open-drain outputs
`default_nettype none
module host_model
(
    input wire logic hostResetNOut,
    input wire logic hostResetNOe_n,
    input wire logic saveWarnNOut,
    input wire logic saveWarnNOe_n,
    output logic hostResetLine,
    output logic saveWarnLine,
    output int resetPulses
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up wins whenever the pin is released
    assign hostResetLine = hostResetNOe_n ? 1'b1 : hostResetNOut;
    assign saveWarnLine = saveWarnNOe_n ? 1'b1 : saveWarnNOut;
    initial resetPulses = 0;
    // only differences used: start-up edge harmless
    always @(negedge hostResetLine)
        resetPulses++;
endmodule
`default_nettype wire

// ===== verif/supply_supervisor_watchdog_test.sv
// supervisor bench
// assumes all sources compiled first
`default_nettype none
module supply_supervisor_watchdog_test;
    timeunit 1ns;
    timeprecision 1ns;
    import supply_supervisor_pkg::*;
    localparam int CPM = 10;
    typedef struct packed { logic [16:0] ins; sup_state_t st; logic [7:0] outs; } row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0, write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [16:0] ins = 17'h0;
    logic [31:0] readdata, rdata;
    logic waitrequest, hostResetNOut, hostResetNOe_n, saveWarnNOut, saveWarnNOe_n;
    logic fixedBuckEn, adjustableBuckEn, oscEnable, hostSerialActive, hostResetLine, saveWarnLine;
    logic [1:0] hostClockMode;
    logic [7:0] outs;
    sup_state_t supState;
    int resetPulses, nErrors = 0, numChecks = 0;
    int toMs[16] = '{33, 66, 98, 131, 164, 197, 229, 262, 295, 328, 360, 393, 426, 459, 492, 524};
    int minMs[16] = '{2, 4, 6, 8, 10, 12, 14, 16, 18, 20, 23, 25, 27, 29, 30, 31};
    // comparator vector: 14v 12v 10v 6v5 fhi flo b20 bhi blo fix adj v20 warn shut osc rate trim
    row_t rows[17] = '{
        {17'h06000, SUP_STARTUP, 8'h20}, {17'h1ef81, SUP_STANDBY, 8'had},
        {17'h1ffe3, SUP_STANDBY, 8'hbd}, {17'h1ffe7, SUP_NORMAL, 8'hff},
        {17'h1ffe5, SUP_NORMAL, 8'hfe}, {17'h1fff5, SUP_STANDBY, 8'hbe},
        {17'h1ffe5, SUP_NORMAL, 8'hfe}, {17'h1ffe1, SUP_STANDBY, 8'hbd},
        {17'h1ffe5, SUP_NORMAL, 8'hfe}, {17'h1fee5, SUP_STANDBY, 8'hbe},
        {17'h1ffe5, SUP_NORMAL, 8'hfe}, {17'h1fbe5, SUP_NORMAL, 8'hbe},
        {17'h1ffe5, SUP_NORMAL, 8'hfe}, {17'h0ffe5, SUP_NORMAL, 8'hbe},
        {17'h07fe5, SUP_NORMAL, 8'h3e}, {17'h06785, SUP_STANDBY, 8'h2e},
        {17'h00705, SUP_RESET, 8'h00}};
    assign outs = {hostResetLine, saveWarnLine, fixedBuckEn, adjustableBuckEn, oscEnable,
        hostSerialActive, hostClockMode};
    supply_supervisor_watchdog #(.CYCLES_PER_MS(CPM)) dut (
        .*, .filteredAbove14v(ins[16]), .filteredAbove12v(ins[15]),
        .filteredAbove10v(ins[14]), .filteredAbove6v5(ins[13]), .filterHighThreshold(ins[12]),
        .filterLowThreshold(ins[11]), .busAbove20v(ins[10]), .busHighThreshold(ins[9]),
        .busLowThreshold(ins[8]), .fixedRailOk(ins[7]), .adjustableRailOk(ins[6]),
        .linear20vRailOk(ins[5]), .thermalWarning(ins[4]), .thermalShutdown(ins[3]),
        .oscRunning(ins[2]), .hostClockRateSel(ins[1]), .trimDone(ins[0]),
        .linear20vEn(), .trimReadReq());
    host_model host (.*);
    always #10 clock = ~clock;
    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            nErrors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkCnt(input int got, input int lo, input int hi);
        numChecks++;
        if (got < lo || got > hi)
        begin
            nErrors++;
            $display("CHECK FAILED %0t count %0d not %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // waits on waitrequest
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        rdata = readdata;
        write <= 1'b0;
        read <= 1'b0;
        chkCnt(n, 1, 19);
    endtask
    task automatic apply(input logic [16:0] v, input int cyc);
        @(posedge clock);
        ins <= v;
        repeat (cyc) @(posedge clock);
    endtask
    task automatic waitLine(input logic v, input int lim, output int n);
        n = 0;
        while (hostResetLine !== v && n < lim)
        begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic endOfTest();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #1500000;
        nErrors++;
        endOfTest();
    end
    initial
    begin
        int n, p;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chkVal({supState, outs, waitrequest}, 32'h1);
        foreach (rows[i])
        begin
            apply(rows[i].ins, 40);
            chkVal({supState, outs}, {rows[i].st, rows[i].outs});
        end
        apply(17'h1ffe5, 100);
        bus(1'b0, 4'h0, 32'h0);
        chkVal(rdata, 32'h1f3);
        bus(1'b0, 4'h8, 32'h0);
        chkVal(rdata, 32'h0);
        // shutdown with the watchdog armed, read while it persists
        bus(1'b1, 4'h4, 32'h1);
        apply(17'h1fffd, 20);
        chkVal(supState, SUP_RESET);
        bus(1'b0, 4'h0, 32'h0);
        chkVal(rdata[3:2], 2'h3);
        bus(1'b0, 4'h0, 32'h0);
        chkVal(rdata[3], 1'b1);
        apply(17'h1ffe5, 100);
        chkVal(supState, SUP_NORMAL);
        bus(1'b0, 4'h0, 32'h0);
        chkVal(rdata[3:2], 2'h2);
        bus(1'b0, 4'h0, 32'h0);
        chkVal(rdata[3], 1'b0);
        bus(1'b0, 4'h4, 32'h0);
        chkVal(rdata[0], 1'b0);
        // enable with its byte lane off must not arm the timer
        p = resetPulses;
        byteenable <= 4'he;
        bus(1'b1, 4'h4, 32'h1);
        byteenable <= 4'hf;
        repeat (400) @(posedge clock);
        chkCnt(resetPulses - p, 0, 0);
        bus(1'b1, 4'h4, 32'h51);
        bus(1'b0, 4'h4, 32'h0);
        chkVal(rdata[7:0], 8'h51);
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b1, 4'h4, 32'h1);
        waitLine(1'b0, 20, n);
        chkCnt(n, 0, 19);
        waitLine(1'b1, 40, n);
        chkCnt(n, CPM - 1, CPM + 1);
        for (int s = 0; s < 16; s++)
        begin
            bus(1'b1, 4'h4, 32'h0);
            bus(1'b1, 4'h4, {24'h0, s[3:0], 4'h1});
            repeat (minMs[s] * CPM + 4) @(posedge clock);
            bus(1'b1, 4'h4, {24'h0, s[3:0], 4'h1});
            waitLine(1'b0, toMs[s] * CPM + 50, n);
            chkCnt(n, toMs[s] * CPM - 4, toMs[s] * CPM + 4);
            waitLine(1'b1, 50, n);
        end
        endOfTest();
    end
endmodule
`default_nettype wire
